// file: core/gpi_pkg.sv
// ------------------------------------------------------------
// shared constants and carriers for the port interrupt block
// ------------------------------------------------------------
package gpi_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int PIN_W = 8;  // pins per port
  localparam int DAT_W = 32; // bus data width
  localparam int ADR_W = 12; // decoded byte address bits
  localparam int SEL_W = 4;  // byte lanes

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFF_SENSE = 12'h404;    // sense select
  localparam logic [11:0] OFF_BOTH = 12'h408;     // both_edges_select
  localparam logic [11:0] OFF_POLARITY = 12'h40c; // event_polarity
  localparam logic [11:0] OFF_IRQ_EN = 12'h410;   // pin_irq_enable
  localparam logic [11:0] OFF_RAW = 12'h414;      // raw_irq_status
  localparam logic [11:0] OFF_MASKED = 12'h418;   // masked_irq_status
  localparam logic [11:0] OFF_CLEAR = 12'h41c;    // irq_clear
  localparam logic [11:0] OFF_ALT = 12'h420;      // alt_function_select

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;    // all interrupt fields
  localparam logic [7:0] ALT_RST_PLAIN = 8'h00; // ordinary ports
  localparam logic [7:0] ALT_RST_PORT_B = 8'h80; // debug pin on bit 7
  localparam logic [7:0] ALT_RST_PORT_C = 8'h0f; // debug pins on 3:0

  // ------------------------------------------------------------
  // converter trigger source pin
  // ------------------------------------------------------------
  localparam int ADC_TRIG_PIN = 4;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  // wishbone request as seen by the slave
  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
    logic [SEL_W-1:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } gpi_wb_req_t;

  // one-cycle write strobe toward the register file
  typedef struct packed {
    logic valid;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
    logic [SEL_W-1:0] sel;
  } gpi_wr_t;

  // synchronised pin view
  typedef struct packed {
    logic [PIN_W-1:0] level;
    logic [PIN_W-1:0] rise;
    logic [PIN_W-1:0] fall;
  } gpi_pins_t;

endpackage

// file: core/gpi_pin_sync.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// two-flop pin synchroniser with edge detection
// ------------------------------------------------------------
module gpi_pin_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raw pad levels
  input wire logic [gpi_pkg::PIN_W-1:0] pin_i,
  // synchronised view
  output gpi_pkg::gpi_pins_t pins_o
);

  // all state of the synchroniser
  typedef struct packed {
    logic [gpi_pkg::PIN_W-1:0] s1;   // first flop, read by s2 only
    logic [gpi_pkg::PIN_W-1:0] s2;   // safe level
    logic [gpi_pkg::PIN_W-1:0] prev; // s2 one cycle back
    logic [2:0] primed;              // fill marker after reset
  } gpi_sync_t;

  gpi_sync_t st;
  gpi_sync_t next_st;

  // next state: shift pins through the chain
  always_comb begin
    next_st = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
    next_st.primed = {st.primed[1:0], 1'b1};
  end

  // register the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // edges are suppressed until the chain holds real samples,
  // so a pin that is high at reset gives no false rise
  always_comb begin
    pins_o.level = st.s2;
    pins_o.rise = st.primed[2] ? (st.s2 & ~st.prev) : '0;
    pins_o.fall = st.primed[2] ? (~st.s2 & st.prev) : '0;
  end

endmodule

// file: core/gpi_wb_slave.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// classic wishbone slave: one wait state, registered answer
// ------------------------------------------------------------
module gpi_wb_slave (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus request and answer
  input gpi_pkg::gpi_wb_req_t req_i,
  output logic ack_o,
  output logic [gpi_pkg::DAT_W-1:0] dat_o,
  // read value for the current address
  input wire logic [gpi_pkg::DAT_W-1:0] rd_data_i,
  // write strobe toward the registers
  output gpi_pkg::gpi_wr_t wr_o
);

  // all state of the slave
  typedef struct packed {
    logic ack;
    logic [gpi_pkg::DAT_W-1:0] dat;
  } gpi_slv_t;

  gpi_slv_t st;
  gpi_slv_t next_st;
  logic live;

  // ack rises one cycle after the request and drops right after
  always_comb begin
    live = req_i.cyc & req_i.stb;
    next_st = st;
    next_st.ack = live & ~st.ack;
    // read data is captured together with the ack
    if (live && !st.ack) begin
      next_st.dat = rd_data_i;
    end
  end

  // register the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // write lands on the edge where the master samples ack high
  always_comb begin
    wr_o.valid = live & req_i.we & st.ack;
    wr_o.adr = req_i.adr;
    wr_o.dat = req_i.dat;
    wr_o.sel = req_i.sel;
    ack_o = st.ack;
    dat_o = st.dat;
  end

endmodule

// file: core/gpi_port.sv
`timescale 1ns/1ps
// Summary of operation
// - edge sense, both-edges set: any transition triggers
// - both-edges clear: single edge chosen by polarity
// - polarity 1 rising/high, 0 falling/low
// - reset clears both-edges, polarity and enable
// - enabled pin drives own and combined interrupt
// - disabled pin raises nothing; raw still recorded
// - raw status shows met conditions, ignores enable
// - masked status is raw and enable
// - clear writes of one reset edge latch
// - unmasked pin four pulses converter trigger
// - alternate bit one selects hardware function
// - alternate field resets zero except debug pins
// - any reset restores alternate defaults
// - upper bits reserved; software keeps them
// - sense one level, zero edge; resets zero
module gpi_port #(
  // alternate function reset pattern for this port
  parameter logic [7:0] ALT_RESET = gpi_pkg::ALT_RST_PLAIN,
  // set on the port that feeds the converter trigger
  parameter logic ADC_TRIG_EN = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic [gpi_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [gpi_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic [gpi_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [gpi_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // pads
  input wire logic [gpi_pkg::PIN_W-1:0] pin_i,
  output logic [gpi_pkg::PIN_W-1:0] pad_do_o,
  output logic [gpi_pkg::PIN_W-1:0] pad_oe_o,
  // software and peripheral drive sources
  input wire logic [gpi_pkg::PIN_W-1:0] sw_do_i,
  input wire logic [gpi_pkg::PIN_W-1:0] sw_oe_i,
  input wire logic [gpi_pkg::PIN_W-1:0] periph_do_i,
  input wire logic [gpi_pkg::PIN_W-1:0] periph_oe_i,
  // mode and interrupts
  output logic [gpi_pkg::PIN_W-1:0] alt_function_bits_o,
  output logic [gpi_pkg::PIN_W-1:0] pin_irq_o,
  output logic port_combined_irq_o,
  output logic adc_trig_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // every flop of the port outside u_sync and u_wb lives in this struct
  typedef struct packed {
    logic [gpi_pkg::PIN_W-1:0] sense_select_bits;   // 1 level, 0 edge
    logic [gpi_pkg::PIN_W-1:0] both_edges_bits;     // any edge
    logic [gpi_pkg::PIN_W-1:0] event_polarity_bits; // 1 rise/high
    logic [gpi_pkg::PIN_W-1:0] pin_irq_enable_bits; // mask enable
    logic [gpi_pkg::PIN_W-1:0] alt_function_bits;   // 1 hardware
    logic [gpi_pkg::PIN_W-1:0] edge_latch;          // sticky edges
    logic [gpi_pkg::PIN_W-1:0] raw_status_bits;     // before mask
    logic [gpi_pkg::PIN_W-1:0] masked_status_bits;  // after mask
    logic combined_irq;                             // or of masked
    logic adc_trig;                                 // one-cycle pulse
    logic [gpi_pkg::PIN_W-1:0] pad_do;              // muxed drive
    logic [gpi_pkg::PIN_W-1:0] pad_oe;              // muxed enable
  } gpi_core_t;

  gpi_core_t st;
  gpi_core_t next_st;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // word address match, byte offset bits ignored
  function automatic logic hit(input logic [gpi_pkg::ADR_W-1:0] adr,
                               input logic [11:0] off);
    hit = (adr[gpi_pkg::ADR_W-1:2] == off[gpi_pkg::ADR_W-1:2]);
  endfunction

  // narrow pin field placed in the low byte, upper bits zero
  function automatic logic [gpi_pkg::DAT_W-1:0] word(
      input logic [gpi_pkg::PIN_W-1:0] v);
    word = {{(gpi_pkg::DAT_W - gpi_pkg::PIN_W){1'b0}}, v};
  endfunction

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  gpi_pkg::gpi_pins_t pins;     // synchronised pad view
  gpi_pkg::gpi_wb_req_t wb_req; // bundled bus request
  gpi_pkg::gpi_wr_t wr;         // write strobe
  logic [gpi_pkg::DAT_W-1:0] rd_data; // read mux result

  // pads come from outside, so they pass two flops first
  gpi_pin_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (pin_i),
    .pins_o (pins)
  );

  // bundle the bus signals for the slave
  always_comb begin
    wb_req.adr = wb_adr_i;
    wb_req.dat = wb_dat_i;
    wb_req.sel = wb_sel_i;
    wb_req.we = wb_we_i;
    wb_req.cyc = wb_cyc_i;
    wb_req.stb = wb_stb_i;
  end

  gpi_wb_slave u_wb (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .req_i (wb_req),
    .ack_o (wb_ack_o),
    .dat_o (wb_dat_o),
    .rd_data_i (rd_data),
    .wr_o (wr)
  );

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // reserved bits 31:8 read zero; unmapped words read zero
  always_comb begin
    rd_data = '0;
    if (hit(wb_adr_i, gpi_pkg::OFF_SENSE)) begin
      rd_data = word(st.sense_select_bits);
    end else if (hit(wb_adr_i, gpi_pkg::OFF_BOTH)) begin
      rd_data = word(st.both_edges_bits);
    end else if (hit(wb_adr_i, gpi_pkg::OFF_POLARITY)) begin
      rd_data = word(st.event_polarity_bits);
    end else if (hit(wb_adr_i, gpi_pkg::OFF_IRQ_EN)) begin
      rd_data = word(st.pin_irq_enable_bits);
    end else if (hit(wb_adr_i, gpi_pkg::OFF_RAW)) begin
      rd_data = word(st.raw_status_bits);
    end else if (hit(wb_adr_i, gpi_pkg::OFF_MASKED)) begin
      // computed from the stored fields so it always agrees
      rd_data = word(st.raw_status_bits & st.pin_irq_enable_bits);
    end else if (hit(wb_adr_i, gpi_pkg::OFF_ALT)) begin
      rd_data = word(st.alt_function_bits);
    end
    // clear register is write-only and reads zero
  end

  // ------------------------------------------------------------
  // detection and register update
  // ------------------------------------------------------------
  logic wr_lane0;                         // low byte written
  logic [gpi_pkg::PIN_W-1:0] level_hit;   // qualifying level
  logic [gpi_pkg::PIN_W-1:0] edge_hit;    // qualifying edge
  logic [gpi_pkg::PIN_W-1:0] edge_evt;    // edge on edge pin
  logic [gpi_pkg::PIN_W-1:0] clear_bits;  // write-one clears
  logic [gpi_pkg::PIN_W-1:0] level_new;   // level raw just rose
  logic trig_src;                         // trigger pin event

  always_comb begin
    next_st = st;
    wr_lane0 = wr.valid & wr.sel[0];
    clear_bits = '0;

    // software writes only the low byte; upper bits are dropped
    if (wr_lane0) begin
      if (hit(wr.adr, gpi_pkg::OFF_SENSE)) begin
        next_st.sense_select_bits = wr.dat[gpi_pkg::PIN_W-1:0];
      end
      if (hit(wr.adr, gpi_pkg::OFF_BOTH)) begin
        next_st.both_edges_bits = wr.dat[gpi_pkg::PIN_W-1:0];
      end
      if (hit(wr.adr, gpi_pkg::OFF_POLARITY)) begin
        next_st.event_polarity_bits = wr.dat[gpi_pkg::PIN_W-1:0];
      end
      if (hit(wr.adr, gpi_pkg::OFF_IRQ_EN)) begin
        next_st.pin_irq_enable_bits = wr.dat[gpi_pkg::PIN_W-1:0];
      end
      if (hit(wr.adr, gpi_pkg::OFF_CLEAR)) begin
        clear_bits = wr.dat[gpi_pkg::PIN_W-1:0];
      end
      if (hit(wr.adr, gpi_pkg::OFF_ALT)) begin
        next_st.alt_function_bits = wr.dat[gpi_pkg::PIN_W-1:0];
      end
    end

    // polarity picks high or low level
    level_hit = ~(pins.level ^ st.event_polarity_bits);

    // both-edges overrides polarity for edge pins
    edge_hit = (st.both_edges_bits & (pins.rise | pins.fall)) |
               (~st.both_edges_bits &
                ((st.event_polarity_bits & pins.rise) |
                 (~st.event_polarity_bits & pins.fall)));

    // only edge-sensed pins feed the latch
    edge_evt = edge_hit & ~st.sense_select_bits;

    // a new edge in the clearing cycle wins, so no event is lost;
    // level pins keep the latch empty so no stale edge shows
    next_st.edge_latch = ((st.edge_latch & ~clear_bits) | edge_evt) &
                         ~st.sense_select_bits;

    // raw follows the level or holds the latched edge
    next_st.raw_status_bits = (st.sense_select_bits & level_hit) |
                              (~st.sense_select_bits & next_st.edge_latch);

    // mask gates outputs but never the raw record
    next_st.masked_status_bits = next_st.raw_status_bits &
                                 next_st.pin_irq_enable_bits;
    next_st.combined_irq = |next_st.masked_status_bits;

    // converter trigger: fresh event on the unmasked trigger pin;
    // a held level only pulses once, when it first qualifies
    level_new = st.sense_select_bits & level_hit & ~st.raw_status_bits;
    trig_src = edge_evt[gpi_pkg::ADC_TRIG_PIN] |
               level_new[gpi_pkg::ADC_TRIG_PIN];
    next_st.adc_trig = ADC_TRIG_EN & trig_src &
                       next_st.pin_irq_enable_bits[gpi_pkg::ADC_TRIG_PIN];

    // pin ownership: hardware function or software registers
    next_st.pad_do = (next_st.alt_function_bits & periph_do_i) |
                     (~next_st.alt_function_bits & sw_do_i);
    next_st.pad_oe = (next_st.alt_function_bits & periph_oe_i) |
                     (~next_st.alt_function_bits & sw_oe_i);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // rst_i covers power-on and external reset alike
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.sense_select_bits <= gpi_pkg::RST_ZERO;
      st.both_edges_bits <= gpi_pkg::RST_ZERO;
      st.event_polarity_bits <= gpi_pkg::RST_ZERO;
      st.pin_irq_enable_bits <= gpi_pkg::RST_ZERO;
      st.alt_function_bits <= ALT_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from flops
  // ------------------------------------------------------------
  always_comb begin
    pad_do_o = st.pad_do;
    pad_oe_o = st.pad_oe;
    alt_function_bits_o = st.alt_function_bits;
    pin_irq_o = st.masked_status_bits;
    port_combined_irq_o = st.combined_irq;
    adc_trig_o = st.adc_trig;
  end

endmodule

// file: verification/gpi_port_props.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port-level checker for the interrupt and alternate-function port
// ------------------------------------------------------------
module gpi_port_props #(
  parameter logic [7:0] ALT_RESET = 8'h00
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone side
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pads and drive sources
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pad_do_o,
  input wire logic [7:0] pad_oe_o,
  input wire logic [7:0] sw_do_i,
  input wire logic [7:0] sw_oe_i,
  input wire logic [7:0] periph_do_i,
  input wire logic [7:0] periph_oe_i,
  // mode and interrupts
  input wire logic [7:0] alt_function_bits_o,
  input wire logic [7:0] pin_irq_o,
  input wire logic port_combined_irq_o,
  input wire logic adc_trig_o
);
  logic [7:0] en_q; // shadow of the enable register
  logic [7:0] en_p; // shadow one cycle older, covers output lag
  logic [1:0] up_cnt; // edges since reset, saturating
  logic en_wr; // accepted write to the enable register
  assign en_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
    && (wb_adr_i[11:2] == gpi_pkg::OFF_IRQ_EN[11:2]);

  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  // shadow follows the write at the ack edge, like the register itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 8'h00;
      en_p <= 8'h00;
      up_cnt <= 2'h0;
    end else begin
      en_p <= en_q;
      if (up_cnt != 2'h3) begin
        up_cnt <= up_cnt + 2'h1;
      end
      if (en_wr) begin
        en_q <= wb_dat_i[7:0];
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  ack_after_req_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  reserved_read_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("reserved read bits not zero");
  clear_reads_zero_a: assert property (wb_ack_o && !wb_we_i
    && wb_adr_i[11:2] == gpi_pkg::OFF_CLEAR[11:2] |-> wb_dat_o == 32'h0)
    else $error("clear register read not zero");
  alt_reset_val_a: assert property ($fell(rst_i) |-> alt_function_bits_o == ALT_RESET)
    else $error("alternate bits wrong after reset");
  masked_pin_quiet_a: assert property ((pin_irq_o & ~(en_q | en_p)) == 8'h00)
    else $error("disabled pin raised its interrupt");
  combined_line_a: assert property (port_combined_irq_o == (|pin_irq_o))
    else $error("combined line differs from pin interrupts");
  trig_unmasked_a: assert property (adc_trig_o |-> pin_irq_o[gpi_pkg::ADC_TRIG_PIN])
    else $error("converter trigger without unmasked pin");
  pad_mux_sel_a: assert property (up_cnt == 2'h3 && $stable(alt_function_bits_o)
    && alt_function_bits_o == $past(alt_function_bits_o, 2) |->
    pad_do_o == ((alt_function_bits_o & $past(periph_do_i)) | (~alt_function_bits_o & $past(sw_do_i)))
    && pad_oe_o == ((alt_function_bits_o & $past(periph_oe_i)) | (~alt_function_bits_o & $past(sw_oe_i))))
    else $error("pad drive not from the selected source");
endmodule

// file: verification/gpi_pin_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// far side: pad levels and a peripheral drive source
// ------------------------------------------------------------
module gpi_pin_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // commanded pad levels
  input wire logic [7:0] level_i,
  // pad and peripheral outputs
  output logic [7:0] pin_o,
  output logic [7:0] periph_do_o,
  output logic [7:0] periph_oe_o
);
  // peripheral pattern tracks the pads so the bench can predict it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 8'h00;
      periph_do_o <= 8'hff;
      periph_oe_o <= 8'h00;
    end else begin
      pin_o <= level_i;
      periph_do_o <= ~level_i;
      periph_oe_o <= {level_i[3:0], level_i[7:4]};
    end
  end
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// bench for one port built as the converter-trigger port
// ------------------------------------------------------------
module tb_top;
  logic clk_i = 1'b0; // 50 MHz system clock
  logic rst_i = 1'b1; // synchronous reset
  logic [11:0] wb_adr_i = 12'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] pin_i, pad_do_o, pad_oe_o, periph_do_i, periph_oe_i, alt_function_bits_o, pin_irq_o;
  logic [7:0] sw_do_i = 8'h0;
  logic [7:0] sw_oe_i = 8'h0;
  logic [7:0] lvl = 8'h0; // commanded pad levels
  logic port_combined_irq_o, adc_trig_o;
  logic [7:0] en, m, c, raw, a, b, p;
  logic [11:0] rw_off [4] = '{gpi_pkg::OFF_SENSE, gpi_pkg::OFF_BOTH, gpi_pkg::OFF_POLARITY,
    gpi_pkg::OFF_IRQ_EN};
  int num_errors = 0;
  int n_checks = 0;
  int seed = 13953;
  int cyc_cnt = 0;
  int k, n;

  always #10 clk_i = ~clk_i;

  gpi_port #(.ALT_RESET(gpi_pkg::ALT_RST_PORT_B), .ADC_TRIG_EN(1'b1)) u_dut (.clk_i, .rst_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .pin_i, .pad_do_o, .pad_oe_o, .sw_do_i, .sw_oe_i, .periph_do_i, .periph_oe_i,
    .alt_function_bits_o, .pin_irq_o, .port_combined_irq_o, .adc_trig_o);
  gpi_pin_model u_pins (.clk_i, .rst_i, .level_i(lvl), .pin_o(pin_i), .periph_do_o(periph_do_i),
    .periph_oe_o(periph_oe_i));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) check("bus ack", 32'h1, 32'h0);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] adr, input logic [7:0] v);
    logic [31:0] d;
    wb(1'b1, adr, {24'h0, v}, d);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] adr, input logic [7:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, d);
    check(what, {24'h0, exp}, d);
  endtask

  // expected raw status: level follows pin, edge latches
  function automatic logic [7:0] exp_raw(input logic [7:0] sense, both, pol, prev, cur, old);
    exp_raw = (sense & ~(cur ^ pol)) | (~sense & (old | (cur & ~prev & (both | pol))
      | (~cur & prev & (both | ~pol))));
  endfunction

  // fixed wait covers the synchroniser fill and status latency
  task automatic pins(input logic [7:0] v);
    @(posedge clk_i);
    lvl <= v;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic irq_chk(input logic [7:0] r, input logic [7:0] e);
    rd_chk("raw", gpi_pkg::OFF_RAW, r);
    rd_chk("masked", gpi_pkg::OFF_MASKED, r & e);
    check("pin_irq", {24'h0, r & e}, {24'h0, pin_irq_o});
    check("combined", {31'h0, |(r & e)}, {31'h0, port_combined_irq_o});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      num_errors++;
      $display("ERROR timeout expected 0 seen 1");
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (k = 0; k < 4; k++) rd_chk("reset reg", rw_off[k], 8'h00);
    rd_chk("raw", gpi_pkg::OFF_RAW, 8'h00);
    rd_chk("alt", gpi_pkg::OFF_ALT, gpi_pkg::ALT_RST_PORT_B);
    check("alt out", {24'h0, gpi_pkg::ALT_RST_PORT_B}, {24'h0, alt_function_bits_o});
    rd_chk("unmapped", 12'h300, 8'h00);
    $display("test reset values done");
    for (k = 0; k < 4; k++) begin
      a = 8'($random(seed));
      wr(rw_off[k], a);
      rd_chk("rw reg", rw_off[k], a);
      wr(rw_off[k], 8'h00);
    end
    wr(gpi_pkg::OFF_CLEAR, 8'hff);
    rd_chk("clear reads", gpi_pkg::OFF_CLEAR, 8'h00);
    wr(gpi_pkg::OFF_RAW, 8'hff);
    rd_chk("raw read-only", gpi_pkg::OFF_RAW, 8'h00);
    $display("test register access done");
    for (k = 0; k < 3; k++) begin
      b = (k == 2) ? 8'hff : 8'h00;
      p = (k == 0) ? 8'hff : 8'h00;
      en = 8'($random(seed));
      m = 8'($random(seed)) | 8'h10;
      wr(gpi_pkg::OFF_BOTH, b);
      wr(gpi_pkg::OFF_POLARITY, p);
      wr(gpi_pkg::OFF_IRQ_EN, en);
      wr(gpi_pkg::OFF_CLEAR, 8'hff);
      raw = exp_raw(8'h0, b, p, 8'h0, m, 8'h0);
      pins(m);
      irq_chk(raw, en);
      raw = exp_raw(8'h0, b, p, m, 8'h0, raw);
      pins(8'h0);
      irq_chk(raw, en);
      wr(gpi_pkg::OFF_CLEAR, 8'h00);
      irq_chk(raw, en);
      c = 8'($random(seed));
      wr(gpi_pkg::OFF_CLEAR, c);
      irq_chk(raw & ~c, en);
    end
    $display("test edge modes done");
    wr(gpi_pkg::OFF_SENSE, 8'hff);
    for (k = 0; k < 2; k++) begin
      p = (k == 1) ? 8'hff : 8'h00;
      m = 8'($random(seed));
      wr(gpi_pkg::OFF_POLARITY, p);
      pins(m);
      irq_chk(exp_raw(8'hff, 8'h0, p, 8'h0, m, 8'h0), en);
      pins(~m);
      irq_chk(exp_raw(8'hff, 8'h0, p, 8'h0, ~m, 8'h0), en);
    end
    pins(8'h0);
    wr(gpi_pkg::OFF_SENSE, 8'h00);
    wr(gpi_pkg::OFF_BOTH, 8'h00);
    wr(gpi_pkg::OFF_POLARITY, 8'hff);
    $display("test level modes done");
    for (k = 0; k < 2; k++) begin
      wr(gpi_pkg::OFF_IRQ_EN, (k == 1) ? 8'h00 : 8'h10);
      wr(gpi_pkg::OFF_CLEAR, 8'hff);
      lvl <= 8'h10;
      n = 0;
      repeat (10) begin
        @(posedge clk_i);
        if (adc_trig_o === 1'b1) n++;
      end
      check("trigger pulses", (k == 1) ? 32'h0 : 32'h1, n);
      pins(8'h0);
    end
    $display("test converter trigger done");
    repeat (4) begin
      a = 8'($random(seed));
      wr(gpi_pkg::OFF_ALT, a);
      sw_do_i <= 8'($random(seed));
      sw_oe_i <= 8'($random(seed));
      lvl <= 8'($random(seed));
      repeat (12) @(posedge clk_i);
      rd_chk("alt", gpi_pkg::OFF_ALT, a);
      check("alt out", {24'h0, a}, {24'h0, alt_function_bits_o});
      check("pad do", {24'h0, (a & ~lvl) | (~a & sw_do_i)}, {24'h0, pad_do_o});
      check("pad oe", {24'h0, (a & {lvl[3:0], lvl[7:4]}) | (~a & sw_oe_i)}, {24'h0, pad_oe_o});
    end
    $display("test alternate function done");
    pins(8'h0);
    wr(gpi_pkg::OFF_IRQ_EN, 8'hff);
    wr(gpi_pkg::OFF_ALT, 8'h00);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("alt", gpi_pkg::OFF_ALT, gpi_pkg::ALT_RST_PORT_B);
    check("alt out", {24'h0, gpi_pkg::ALT_RST_PORT_B}, {24'h0, alt_function_bits_o});
    rd_chk("en", gpi_pkg::OFF_IRQ_EN, 8'h00);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule

bind gpi_port gpi_port_props #(.ALT_RESET(ALT_RESET)) u_props (.clk_i, .rst_i, .wb_adr_i,
  .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .pin_i, .pad_do_o,
  .pad_oe_o, .sw_do_i, .sw_oe_i, .periph_do_i, .periph_oe_i, .alt_function_bits_o, .pin_irq_o,
  .port_combined_irq_o, .adc_trig_o);
